// file: rtl/ilpc_pkg.sv
/*
 * Package of the interrupt and low-power controller: register addresses,
 * field positions, source order, vectors, timing figures and shared types.
 * Assumes a single processor clock at twice the input clock rate.
 */
`default_nettype none

package ilpc_pkg;

  // ----------------------------------------------------------------------
  // Register addresses and fields
  // ----------------------------------------------------------------------
  localparam logic [13:0] DM_SERIAL0_ABUF_CTRL = 14'h3ff3;
  localparam int ABUF_PROCESSOR_CLOCK_OUTPUT_DIS_BIT = 14;
  localparam logic [15:0] ABUF_RESET = 16'h0000;
  // Interrupt control: sense selection of the three request pins, nesting.
  localparam int INTERRUPT_CONTROL_REG_EDGE_ZERO = 0;
  localparam int INTERRUPT_CONTROL_REG_EDGE_ONE = 1;
  localparam int INTERRUPT_CONTROL_REG_EDGE_TWO = 2;
  localparam int INTERRUPT_CONTROL_REG_NEST = 4;
  localparam logic [4:0] INTERRUPT_CONTROL_REG_RESET = 5'h00;
  // Force/clear word: force bits low, clear bits high.
  localparam int IFC_FORCE_SW0 = 0;
  localparam int IFC_FORCE_SW1 = 1;
  localparam int IFC_FORCE_PWD = 2;
  localparam int IFC_CLEAR_SW0 = 8;
  localparam int IFC_CLEAR_SW1 = 9;
  localparam logic [9:0] MASK_RESET = 10'h000;

  // ----------------------------------------------------------------------
  // Sources, index 0 has the highest priority
  // ----------------------------------------------------------------------
  localparam int NUM_SRC = 11;
  localparam int SRC_PWD = 0;
  localparam int SRC_REQ2 = 1;
  localparam int SRC_HWR = 2;
  localparam int SRC_HRD = 3;
  localparam int SRC_S0TX = 4;
  localparam int SRC_S0RX = 5;
  localparam int SRC_SW1 = 6;
  localparam int SRC_SW0 = 7;
  localparam int SRC_S1TX = 8;
  localparam int SRC_S1RX = 9;
  localparam int SRC_TIMER = 10;
  localparam logic [3:0] LEVEL_NONE = 4'hf;
  localparam logic [13:0] VEC_RESET = 14'h0000;

  // Returns the vector address of a source index.
  function automatic logic [13:0] vector_of(input logic [3:0] idx);
    case (idx)
      4'h0: vector_of = 14'h002c;
      4'h1: vector_of = 14'h0004;
      4'h2: vector_of = 14'h0008;
      4'h3: vector_of = 14'h000c;
      4'h4: vector_of = 14'h0010;
      4'h5: vector_of = 14'h0014;
      4'h6: vector_of = 14'h0018;
      4'h7: vector_of = 14'h001c;
      4'h8: vector_of = 14'h0020;
      4'h9: vector_of = 14'h0024;
      default: vector_of = 14'h0028;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SOFT_RESET_CYCLES = 5;
  localparam int CYC_PER_INPUT_CLOCK = 2;
  localparam int WAKE_FAST_INPUT_CLOCK = 100;
  localparam int WAKE_OSC_INPUT_CLOCK = 4096;
  localparam int STACK_DEPTH = 12;
  localparam int SLOW_DIV_BASE = 16;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PD_RUN = 2'b00,
    PD_ARMED = 2'b01,
    PD_SLEEP = 2'b10,
    PD_WAKE = 2'b11
  } ilpc_pd_t;

  typedef struct packed {
    logic [3:0] level;
    logic [15:0] status;
  } ilpc_entry_t;

endpackage

`default_nettype wire

// file: rtl/ilpc_stack.sv
/*
 * Status stack used on interrupt entry and return.
 * Assumes push and pop are never both requested in one cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module ilpc_stack #(
  parameter int DEPTH = ilpc_pkg::STACK_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire ilpc_pkg::ilpc_entry_t din_i,
  output ilpc_pkg::ilpc_entry_t dout_o,
  output logic empty_o,
  output logic overflow_o
);

  ilpc_pkg::ilpc_entry_t mem [DEPTH];
  logic [4:0] depth;

  // ----------------------------------------------------------------------
  // Storage and pointer
  // ----------------------------------------------------------------------
  // A push onto a full stack is dropped and flagged, a pop when empty is
  // ignored so the pointer never wraps.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      depth <= 5'h00;
      overflow_o <= 1'b0;
    end else if (push_i) begin
      if (depth == 5'(DEPTH)) begin
        overflow_o <= 1'b1;
      end else begin
        depth <= depth + 5'h01;
      end
    end else if (pop_i && depth != 5'h00) begin
      depth <= depth - 5'h01;
    end
  end

  // Entry writes need no reset.
  always_ff @(posedge clk_sys_i) begin
    if (push_i && depth != 5'(DEPTH)) begin
      mem[depth[3:0]] <= din_i;
    end
  end

  // Top of stack and empty indication.
  assign dout_o = (depth == 5'h00) ? '0 : mem[4'(depth - 5'h01)];
  assign empty_o = (depth == 5'h00);

endmodule

`default_nettype wire

// file: rtl/ilpc_top.sv
/*
 * Interrupt and low-power controller: request sensing, masking, fixed
 * priority selection, nesting with a status stack, host soft reset,
 * powerdown with wake-up timing, idle and slow idle.
 * Assumes all inputs are synchronous to clk_sys_i and that instruction
 * strobes from the core are one-cycle pulses.
 */
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - A host soft reset request holds soft reset high for five cycles.
// - Eleven sources besides reset: three pins, timer, host, serial, soft, pwd.
// - Fixed priority order and vector table, reset highest, timer lowest.
// - All levels except powerdown and reset have a mask bit.
// - Pending requests are ANDed with mask; highest surviving one is taken.
// - One cycle after a mask write no interrupt is taken.
// - Control register picks edge or level sensing per request pin.
// - Nested mode lets higher levels preempt; sequential waits for return.
// - Write-only force/clear word sets or clears software interrupts.
// - Status is pushed on entry and popped on return, twelve deep.
// - Global on/off gates all servicing, powerdown included, over the mask.
// - Global servicing is enabled after reset.
// - Bit 14 of serial-0 autobuffer control at 0x3ff3 gates clock out.
// - With clock kept running, wake takes 100 input clocks.
// - With oscillator stopped, wake waits 4096 input clocks.
// - Powerdown starts from the pin or the software force bit.
// - Powerdown request is an edge, unmaskable interrupt; handler commits.
// - On wake, context setting selects resume or restart with clean context.
// - Reset pin ends powerdown; host soft reset ends it when asleep.
// - Acknowledge output is high once powerdown is fully entered.
// - Idle stalls until an unmasked interrupt, serves it, then continues.
// - Slow idle divides clocks by 16..128; wake waits up to n cycles.
module ilpc_top #(
  parameter int STAT_W = 16,
  parameter int WAKE_OSC_CYCLES =
    ilpc_pkg::WAKE_OSC_INPUT_CLOCK * ilpc_pkg::CYC_PER_INPUT_CLOCK
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ext_request_zero_n_i,
  input wire logic ext_request_one_n_i,
  input wire logic ext_request_two_n_i,
  input wire logic powerdown_pin_n_i,
  input wire logic timer_req_i,
  input wire logic host_wr_req_i,
  input wire logic host_rd_req_i,
  input wire logic s0_tx_req_i,
  input wire logic s0_rx_req_i,
  input wire logic s1_tx_req_i,
  input wire logic s1_rx_req_i,
  input wire logic s1_as_requests_i,
  input wire logic host_soft_reset_req_i,
  input wire logic osc_stopped_i,
  input wire logic powerup_context_reset_i,
  input wire logic mask_we_i,
  input wire logic [9:0] mask_wdata_i,
  input wire logic ctrl_we_i,
  input wire logic [4:0] ctrl_wdata_i,
  input wire logic force_clear_we_i,
  input wire logic [15:0] force_clear_wdata_i,
  input wire logic global_interrupt_on_i,
  input wire logic global_interrupt_off_i,
  input wire logic return_i,
  input wire logic [STAT_W-1:0] status_i,
  input wire logic pd_commit_i,
  input wire logic idle_i,
  input wire logic [1:0] idle_div_sel_i,
  input wire logic idle_slow_i,
  input wire logic dm_we_i,
  input wire logic dm_re_i,
  input wire logic [13:0] dm_addr_i,
  input wire logic [15:0] dm_wdata_i,
  output logic [15:0] dm_rdata_o,
  output logic int_take_o,
  output logic [13:0] int_vector_o,
  output logic [STAT_W-1:0] status_o,
  output logic stack_overflow_o,
  output logic [10:0] pending_o,
  output logic global_enable_o,
  output logic soft_reset_o,
  output logic powerdown_acknowledge_o,
  output logic pd_resume_o,
  output logic pd_context_clear_o,
  output logic stall_o,
  output logic slow_tick_o,
  output logic processor_clock_output_en_o
);

  localparam int N = ilpc_pkg::NUM_SRC;
  localparam logic [12:0] WAKE_FAST_CYCLES =
    13'(ilpc_pkg::WAKE_FAST_INPUT_CLOCK * ilpc_pkg::CYC_PER_INPUT_CLOCK - 1);
  localparam logic [12:0] WAKE_OSC_CNT = 13'(WAKE_OSC_CYCLES - 1);
  localparam logic [2:0] SOFT_RST_CNT = 3'(ilpc_pkg::SOFT_RESET_CYCLES);

  logic [9:0] interrupt_mask_reg;
  logic [4:0] interrupt_control_reg;
  logic [15:0] serial0_autobuffer_control;
  logic gie;
  logic mask_block;
  logic [N-1:0] raw_req;
  logic [N-1:0] raw_q;
  logic [N-1:0] edge_mode;
  logic [N-1:0] force_set;
  logic [N-1:0] soft_clear;
  logic [N-1:0] latched;
  logic [N-1:0] pending;
  logic [N-1:0] eligible;
  logic [3:0] sel;
  logic sel_valid;
  logic [3:0] cur_level;
  logic take;
  logic [2:0] soft_cnt;
  ilpc_pkg::ilpc_pd_t pd_state;
  logic [12:0] wake_cnt;
  logic pd_restart;
  logic idle_q;
  logic slow_q;
  logic [6:0] slow_cnt;
  logic [6:0] slow_div;
  logic slow_ok;
  ilpc_pkg::ilpc_entry_t stack_top;
  logic stack_empty;
  logic stack_push;
  logic stack_pop;

  // ----------------------------------------------------------------------
  // Request sensing
  // ----------------------------------------------------------------------
  // Source vector in priority order; serial port 1 lines double as pins.
  always_comb begin
    raw_req = '0;
    raw_req[ilpc_pkg::SRC_PWD] = !powerdown_pin_n_i;
    raw_req[ilpc_pkg::SRC_REQ2] = !ext_request_two_n_i;
    raw_req[ilpc_pkg::SRC_HWR] = host_wr_req_i;
    raw_req[ilpc_pkg::SRC_HRD] = host_rd_req_i;
    raw_req[ilpc_pkg::SRC_S0TX] = s0_tx_req_i;
    raw_req[ilpc_pkg::SRC_S0RX] = s0_rx_req_i;
    raw_req[ilpc_pkg::SRC_S1TX] = s1_as_requests_i ?
      !ext_request_one_n_i : s1_tx_req_i;
    raw_req[ilpc_pkg::SRC_S1RX] = s1_as_requests_i ?
      !ext_request_zero_n_i : s1_rx_req_i;
    raw_req[ilpc_pkg::SRC_TIMER] = timer_req_i;
  end

  // Only the request pins may be level sensed; all else is edge sensed.
  always_comb begin
    edge_mode = '1;
    edge_mode[ilpc_pkg::SRC_REQ2] =
      interrupt_control_reg[ilpc_pkg::INTERRUPT_CONTROL_REG_EDGE_TWO];
    edge_mode[ilpc_pkg::SRC_S1TX] = !s1_as_requests_i ||
      interrupt_control_reg[ilpc_pkg::INTERRUPT_CONTROL_REG_EDGE_ONE];
    edge_mode[ilpc_pkg::SRC_S1RX] = !s1_as_requests_i ||
      interrupt_control_reg[ilpc_pkg::INTERRUPT_CONTROL_REG_EDGE_ZERO];
  end

  // Software forces and clears decoded from the write-only word.
  always_comb begin
    force_set = '0;
    soft_clear = '0;
    if (force_clear_we_i) begin
      force_set[ilpc_pkg::SRC_SW0] =
        force_clear_wdata_i[ilpc_pkg::IFC_FORCE_SW0];
      force_set[ilpc_pkg::SRC_SW1] =
        force_clear_wdata_i[ilpc_pkg::IFC_FORCE_SW1];
      force_set[ilpc_pkg::SRC_PWD] =
        force_clear_wdata_i[ilpc_pkg::IFC_FORCE_PWD];
      soft_clear[ilpc_pkg::SRC_SW0] =
        force_clear_wdata_i[ilpc_pkg::IFC_CLEAR_SW0];
      soft_clear[ilpc_pkg::SRC_SW1] =
        force_clear_wdata_i[ilpc_pkg::IFC_CLEAR_SW1];
    end
  end

  // Previous request levels for edge detection.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_q <= '0;
    end else begin
      raw_q <= raw_req;
    end
  end

  // Per source pending latch; a new edge wins over service or clear.
  for (genvar i = 0; i < N; i++) begin : g_src
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        latched[i] <= 1'b0;
      end else if ((raw_req[i] && !raw_q[i]) || force_set[i]) begin
        latched[i] <= 1'b1;
      end else if ((take && sel == 4'(i)) || soft_clear[i]) begin
        latched[i] <= 1'b0;
      end
    end
    assign pending[i] = edge_mode[i] ? latched[i] : raw_req[i];
    if (i == ilpc_pkg::SRC_PWD) begin : g_nomask
      assign eligible[i] = pending[i];
    end else begin : g_mask
      assign eligible[i] = pending[i] && interrupt_mask_reg[i-1];
    end
  end

  // ----------------------------------------------------------------------
  // Selection and service
  // ----------------------------------------------------------------------
  // Lowest index among eligible sources wins.
  always_comb begin
    sel = ilpc_pkg::LEVEL_NONE;
    sel_valid = 1'b0;
    for (int k = N - 1; k >= 0; k--) begin
      if (eligible[k]) begin
        sel = 4'(k);
        sel_valid = 1'b1;
      end
    end
  end

  // Take conditions: enable, mask guard cycle, mode, power and idle state.
  always_comb begin
    take = sel_valid && gie && !mask_block && !return_i;
    if (interrupt_control_reg[ilpc_pkg::INTERRUPT_CONTROL_REG_NEST]) begin
      take = take && sel < cur_level;
    end else begin
      take = take && cur_level == ilpc_pkg::LEVEL_NONE;
    end
    take = take && !soft_reset_o && slow_ok &&
      (pd_state == ilpc_pkg::PD_RUN || pd_state == ilpc_pkg::PD_ARMED);
  end

  assign stack_push = take;
  assign stack_pop = return_i;

  // Status stack: level in service and core status travel together.
  ilpc_stack #(
    .DEPTH(ilpc_pkg::STACK_DEPTH)
  ) u_stack (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .push_i(stack_push),
    .pop_i(stack_pop),
    .din_i({cur_level, 16'(status_i)}),
    .dout_o(stack_top),
    .empty_o(stack_empty),
    .overflow_o(stack_overflow_o)
  );

  // Level in service, vector pulse and restored status.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_level <= ilpc_pkg::LEVEL_NONE;
      int_take_o <= 1'b0;
      int_vector_o <= ilpc_pkg::VEC_RESET;
      status_o <= '0;
    end else begin
      int_take_o <= take || pd_restart;
      if (pd_restart) begin
        cur_level <= ilpc_pkg::LEVEL_NONE;
        int_vector_o <= ilpc_pkg::VEC_RESET;
      end else if (take) begin
        cur_level <= sel;
        int_vector_o <= ilpc_pkg::vector_of(sel);
      end else if (return_i && !stack_empty) begin
        cur_level <= stack_top.level;
        status_o <= STAT_W'(stack_top.status);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software visible control
  // ----------------------------------------------------------------------
  // Mask, control, global enable and the one-cycle guard after a mask write.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interrupt_mask_reg <= ilpc_pkg::MASK_RESET;
      interrupt_control_reg <= ilpc_pkg::INTERRUPT_CONTROL_REG_RESET;
      gie <= 1'b1;
      mask_block <= 1'b0;
    end else begin
      mask_block <= mask_we_i;
      if (mask_we_i) begin
        interrupt_mask_reg <= mask_wdata_i;
      end
      if (ctrl_we_i) begin
        interrupt_control_reg <= ctrl_wdata_i;
      end
      if (global_interrupt_on_i) begin
        gie <= 1'b1;
      end else if (global_interrupt_off_i) begin
        gie <= 1'b0;
      end
    end
  end

  // Autobuffer control word at its data address; read data registered.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial0_autobuffer_control <= ilpc_pkg::ABUF_RESET;
      dm_rdata_o <= 16'h0000;
    end else begin
      if (dm_we_i && dm_addr_i == ilpc_pkg::DM_SERIAL0_ABUF_CTRL) begin
        serial0_autobuffer_control <= dm_wdata_i;
      end
      if (dm_re_i && dm_addr_i == ilpc_pkg::DM_SERIAL0_ABUF_CTRL) begin
        dm_rdata_o <= serial0_autobuffer_control;
      end else begin
        dm_rdata_o <= 16'h0000;
      end
    end
  end

  // Status outputs for the core.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_o <= '0;
      global_enable_o <= 1'b1;
      processor_clock_output_en_o <= 1'b1;
    end else begin
      pending_o <= pending;
      global_enable_o <= gie;
      processor_clock_output_en_o <= !serial0_autobuffer_control[
        ilpc_pkg::ABUF_PROCESSOR_CLOCK_OUTPUT_DIS_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Host soft reset
  // ----------------------------------------------------------------------
  // Counts the held cycles; a new request restarts the count.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_cnt <= 3'h0;
      soft_reset_o <= 1'b0;
    end else if (host_soft_reset_req_i) begin
      soft_cnt <= SOFT_RST_CNT - 3'h1;
      soft_reset_o <= 1'b1;
    end else if (soft_cnt != 3'h0) begin
      soft_cnt <= soft_cnt - 3'h1;
    end else begin
      soft_reset_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Powerdown
  // ----------------------------------------------------------------------
  // Arm on the powerdown service, sleep on commit, wake on pin release or
  // soft reset, then wait the recovery time before execution resumes.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd_state <= ilpc_pkg::PD_RUN;
      wake_cnt <= 13'h0000;
      powerdown_acknowledge_o <= 1'b0;
      pd_resume_o <= 1'b0;
      pd_context_clear_o <= 1'b0;
      pd_restart <= 1'b0;
    end else begin
      pd_resume_o <= 1'b0;
      pd_context_clear_o <= 1'b0;
      pd_restart <= 1'b0;
      unique case (pd_state)
        ilpc_pkg::PD_RUN: begin
          if (take && sel == 4'(ilpc_pkg::SRC_PWD)) begin
            pd_state <= ilpc_pkg::PD_ARMED;
          end
        end
        ilpc_pkg::PD_ARMED: begin
          if (pd_commit_i) begin
            pd_state <= ilpc_pkg::PD_SLEEP;
            powerdown_acknowledge_o <= 1'b1;
          end
        end
        ilpc_pkg::PD_SLEEP: begin
          if (powerdown_pin_n_i || host_soft_reset_req_i) begin
            pd_state <= ilpc_pkg::PD_WAKE;
            powerdown_acknowledge_o <= 1'b0;
            wake_cnt <= osc_stopped_i ? WAKE_OSC_CNT : WAKE_FAST_CYCLES;
          end
        end
        ilpc_pkg::PD_WAKE: begin
          if (wake_cnt != 13'h0000) begin
            wake_cnt <= wake_cnt - 13'h0001;
          end else begin
            pd_state <= ilpc_pkg::PD_RUN;
            pd_context_clear_o <= powerup_context_reset_i;
            pd_restart <= powerup_context_reset_i;
            pd_resume_o <= !powerup_context_reset_i;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Idle and slow idle
  // ----------------------------------------------------------------------
  // Divisor minus one: 16, 32, 64 or 128.
  assign slow_div = 7'((ilpc_pkg::SLOW_DIV_BASE << idle_div_sel_i) - 1);
  // In slow idle an interrupt is only taken on a divided clock edge.
  assign slow_ok = !(idle_q && slow_q) || slow_cnt == 7'h00;

  // Idle state: stall until a take, then resume after the idle instruction.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_q <= 1'b0;
      slow_q <= 1'b0;
      slow_cnt <= 7'h00;
      stall_o <= 1'b0;
    end else begin
      if (idle_i && !idle_q) begin
        idle_q <= 1'b1;
        slow_q <= idle_slow_i;
        slow_cnt <= slow_div;
        stall_o <= 1'b1;
      end else if (idle_q && take) begin
        idle_q <= 1'b0;
        slow_q <= 1'b0;
        stall_o <= 1'b0;
      end else if (idle_q && slow_q) begin
        slow_cnt <= (slow_cnt == 7'h00) ? slow_div
                                        : slow_cnt - 7'h01;
      end
    end
  end

  // Divided clock enable for core, serial clock, clock out and timer.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_tick_o <= 1'b1;
    end else begin
      slow_tick_o <= !(idle_q && slow_q) || slow_cnt == 7'h00;
    end
  end

endmodule

`default_nettype wire

// file: tb/ilpc_properties.sv
/* Checker of the interrupt and low-power controller ports.
   Assumes binding to ilpc_top, one processor clock domain. */
`timescale 1ns/100ps
`default_nettype none
module ilpc_properties (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic host_soft_reset_req_i,
  input wire logic mask_we_i,
  input wire logic global_interrupt_on_i,
  input wire logic global_interrupt_off_i,
  input wire logic pd_commit_i,
  input wire logic powerdown_pin_n_i,
  input wire logic soft_reset_o,
  input wire logic int_take_o,
  input wire logic [13:0] int_vector_o,
  input wire logic global_enable_o,
  input wire logic powerdown_acknowledge_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Soft reset is exactly five cycles long.
  a_soft_len: assert property (
    host_soft_reset_req_i |=> soft_reset_o [*5]) else $error("short soft reset");
  a_soft_end: assert property (
    host_soft_reset_req_i ##1 !host_soft_reset_req_i [*5] |=> !soft_reset_o)
    else $error("long soft reset");
  a_mask_guard: assert property (
    mask_we_i |-> ##2 !int_take_o) else $error("take after mask write");
  a_enable_hold: assert property (
    !global_interrupt_off_i ##1 global_enable_o |=> global_enable_o)
    else $error("enable lost");
  a_enable_drop: assert property (
    global_interrupt_off_i && !global_interrupt_on_i |-> ##2 !global_enable_o)
    else $error("enable kept");
  a_enable_gate: assert property (
    !global_enable_o |-> !int_take_o || int_vector_o == 14'h0000)
    else $error("take while off");
  a_ack_cause: assert property (
    $rose(powerdown_acknowledge_o) |-> $past(pd_commit_i))
    else $error("ack without commit");
  a_ack_hold: assert property (
    powerdown_acknowledge_o && !powerdown_pin_n_i && !host_soft_reset_req_i
    |=> powerdown_acknowledge_o) else $error("ack dropped");
endmodule
bind ilpc_top ilpc_properties u_props (.*);
`default_nettype wire

// file: tb/ilpc_core_model.sv
/* Core model: answers each take of a nonzero vector with a return and commits powerdown.
   Assumes one-cycle take pulses from the controller. */
`timescale 1ns/100ps
`default_nettype none
module ilpc_core_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic int_take_i,
  input wire logic [13:0] int_vector_i,
  input wire logic slow_i,
  output logic return_o,
  output logic pd_commit_o
);
  logic [11:0] pipe;
  // Handlers return after a short or long body; powerdown handler commits.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe <= 12'h000;
      pd_commit_o <= 1'b0;
    end else begin
      pipe <= {pipe[10:0], int_take_i && int_vector_i != 14'h0000};
      pd_commit_o <= int_take_i && int_vector_i == 14'h002c;
    end
  end
  assign return_o = slow_i ? pipe[11] : pipe[1];
endmodule
`default_nettype wire

// file: tb/tb.sv
/* Self-checking bench of the interrupt and low-power controller.
   Assumes the core model drives return and powerdown commit. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, powerdown_pin_n_i = 1'b1;
  logic host_soft_reset_req_i = 1'b0, osc_stopped_i = 1'b0, idle_i = 1'b0;
  logic mask_we_i = 1'b0, ctrl_we_i = 1'b0, force_clear_we_i = 1'b0;
  logic global_interrupt_on_i = 1'b0, global_interrupt_off_i = 1'b0;
  logic dm_we_i = 1'b0, dm_re_i = 1'b0, idle_slow_i = 1'b0, powerup_context_reset = 1'b0;
  logic [9:0] mask_wdata_i = 10'h000;
  logic [4:0] ctrl_wdata_i = 5'h00;
  logic [15:0] force_clear_wdata_i = 16'h0000, dm_wdata_i = 16'h4000;
  logic [13:0] dm_addr_i = 14'h3ff3, int_vector_o;
  logic [7:0] req = 8'h00;
  logic return_i, pd_commit_i, int_take_o, stack_overflow_o, stall_o;
  logic soft_reset_o, powerdown_acknowledge_o, pd_resume_o, global_enable_o;
  logic pd_context_clear_o, slow_tick_o, processor_clock_output_en_o;
  logic [15:0] dm_rdata_o, status_o;
  logic [10:0] pending_o;
  int n_mismatch = 0, comparisons = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  ilpc_top #(.WAKE_OSC_CYCLES(20)) dut (.*, .ext_request_zero_n_i(1'b1),
    .ext_request_one_n_i(1'b1), .ext_request_two_n_i(~req[7]),
    .timer_req_i(req[0]), .host_wr_req_i(req[1]), .host_rd_req_i(req[2]),
    .s0_tx_req_i(req[3]), .s0_rx_req_i(req[4]), .s1_tx_req_i(req[5]),
    .s1_rx_req_i(req[6]), .s1_as_requests_i(1'b0), .idle_div_sel_i(2'h0),
    .powerup_context_reset_i(powerup_context_reset), .status_i({8'h00, req}));
  ilpc_core_model core (.clk_sys_i, .rst_n_i, .int_take_i(int_take_o),
    .int_vector_i(int_vector_o), .slow_i(idle_slow_i), .return_o(return_i),
    .pd_commit_o(pd_commit_i));
  // ------------------------------------------------------------
  // Helpers and scenarios
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  task automatic wait_take(input logic [13:0] exp);
    for (int i = 0; i < 60 && int_take_o !== 1'b1; i++) tick(1);
    check({int_take_o, 1'b0, int_vector_o}, {2'h2, exp});
    tick(1);
  endtask
  task automatic write_mask(input logic [9:0] m);
    mask_wdata_i = m;
    mask_we_i = 1'b1;
    tick(1);
    mask_we_i = 1'b0;
    tick(2);
  endtask
  task automatic t_soft_prio;
    int n = 0;
    check({14'h0, global_enable_o, processor_clock_output_en_o}, 16'h0003);
    host_soft_reset_req_i = 1'b1;
    tick(1);
    host_soft_reset_req_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      n += (soft_reset_o === 1'b1);
      tick(1);
    end
    check(16'(n), 16'h0005);
    write_mask(10'h3ff);
    req = 8'h03;
    wait_take(14'h0008);
    wait_take(14'h0028);
    req = 8'h00;
    tick(4);
  endtask
  task automatic t_sources;
    logic [13:0] vt [8] = '{14'h0028, 14'h0008, 14'h000c, 14'h0010,
      14'h0014, 14'h0020, 14'h0024, 14'h0004};
    for (int k = 0; k < 8; k++) begin
      req[k] = 1'b1;
      wait_take(vt[k]);
      req[k] = 1'b0;
      tick(4);
    end
  endtask
  task automatic t_mask_global;
    write_mask(10'h040);
    force_clear_wdata_i = 16'h0001;
    force_clear_we_i = 1'b1;
    tick(1);
    force_clear_we_i = 1'b0;
    wait_take(14'h001c);
    req[0] = 1'b1;
    global_interrupt_off_i = 1'b1;
    tick(10);
    global_interrupt_off_i = 1'b0;
    check({15'h0, pending_o[10]}, 16'h0001);
    check({1'b0, global_enable_o, int_vector_o}, 16'h001c);
    write_mask(10'h200);
    tick(6);
    check({2'h0, int_vector_o}, 16'h001c);
    global_interrupt_on_i = 1'b1;
    tick(1);
    global_interrupt_on_i = 1'b0;
    wait_take(14'h0028);
    req[0] = 1'b0;
    dm_we_i = 1'b1;
    tick(1);
    dm_we_i = 1'b0;
    dm_re_i = 1'b1;
    tick(1);
    dm_re_i = 1'b0;
    check({dm_rdata_o[15:1], processor_clock_output_en_o}, 16'h4000);
  endtask
  task automatic t_idle;
    idle_i = 1'b1;
    tick(1);
    idle_i = 1'b0;
    req[0] = 1'b1;
    check({15'h0, stall_o}, 16'h0001);
    wait_take(14'h0028);
    req[0] = 1'b0;
    check({15'h0, stall_o}, 16'h0000);
  endtask
  task automatic t_pd(input logic osc, input int w, input logic ctx);
    int n;
    osc_stopped_i = osc;
    powerup_context_reset = ctx;
    powerdown_pin_n_i = 1'b0;
    wait_take(14'h002c);
    tick(3);
    check({15'h0, powerdown_acknowledge_o}, 16'h0001);
    powerdown_pin_n_i = 1'b1;
    for (n = 0; n < 400 && {pd_resume_o, pd_context_clear_o} === 2'b00; n++)
      tick(1);
    check(16'({pd_context_clear_o, pd_resume_o}), 16'({ctx, !ctx}));
    check(16'(n >= w && n <= w + 6), 16'h0001);
    tick(1);
    check({int_take_o, 1'b0, int_vector_o},
      ctx ? 16'h8000 : 16'h002c);
    tick(4);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence after a reset of twelve cycles.
  initial begin
    tick(12);
    rst_n_i = 1'b1;
    tick(1);
    t_soft_prio();
    t_sources();
    t_mask_global();
    t_idle();
    t_pd(1'b0, 200, 1'b0);
    t_pd(1'b1, 20, 1'b1);
    print_verdict();
  end
  // Watchdog well beyond the expected run time.
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
